// ==== lblm_pkg.sv ====
// Shared constants for the lighting bus lamp manager: register map, fields,
// trigger positions, lamp command codes and bus timing.
// Assumes a 200 MHz system clock.
package lblm_pkg;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int HALF_BIT_NS     = 208333;
  localparam int ANSWER_WAIT_NS  = 9170000;
  localparam int HALF_BIT_CYC    = HALF_BIT_NS / CLK_PERIOD_NS;
  localparam int ANSWER_WAIT_CYC = ANSWER_WAIT_NS / CLK_PERIOD_NS;
  localparam int CNT_W           = 22;
  localparam int FWD_BITS        = 16;
  localparam int BACK_BITS       = 8;
  localparam int HALF_TOTAL      = 2 * (FWD_BITS + 1);

  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_VALUE  = 8'h04;
  localparam logic [7:0] OFS_TRIG   = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_COUNT  = 8'h10;
  localparam logic [7:0] OFS_STATE  = 8'h14;

  localparam int CFG_LINE_LSB = 0;
  localparam int CFG_TYPE_BIT = 3;
  localparam int CFG_SYNC_BIT = 4;
  localparam int CFG_ADDR_LSB = 8;
  localparam int VAL_BRT_LSB  = 0;
  localparam int VAL_SCN_LSB  = 8;

  localparam int TRG_MAX   = 0;
  localparam int TRG_MIN   = 1;
  localparam int TRG_OFF   = 2;
  localparam int TRG_DIM   = 3;
  localparam int TRG_SCENE = 4;
  localparam int TRG_READ  = 5;
  localparam int TRG_N     = 6;

  localparam logic [2:0] GROUP_PREFIX = 3'b100;
  localparam logic [7:0] CMD_OFF      = 8'h00;
  localparam logic [7:0] CMD_MAX      = 8'h05;
  localparam logic [7:0] CMD_MIN      = 8'h06;
  localparam logic [7:0] CMD_SCENE    = 8'h10;
  localparam logic [7:0] CMD_Q_STATUS = 8'h90;
  localparam logic [7:0] CMD_Q_LEVEL  = 8'ha0;
  localparam logic [7:0] CMD_Q_FAULT  = 8'hf1;

  localparam logic [1:0] STEP_LEVEL  = 2'h0;
  localparam logic [1:0] STEP_STATUS = 2'h1;
  localparam logic [1:0] STEP_FAULT  = 2'h2;
endpackage

// ==== lblm_edge.sv ====
// Rising-edge detector for a group of trigger levels.
// Inputs come from logic on the same clock; no synchroniser here.
`timescale 1ns/1ps
module lblm_edge #(
  parameter int W = 6
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] level_i,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] prev_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_reg <= '0;
    end else if (ce_i) begin
      prev_reg <= level_i;
    end
  end

  // A held-high level yields one pulse only; frozen while ce_i is low.
  assign rise_o = level_i & ~prev_reg & {W{ce_i}};
endmodule

// ==== lblm_link.sv ====
// Bit-serial lamp bus port: sends one biphase forward frame, then optionally
// waits for and receives an eight-bit answer frame.
// Assumes the bus idles high and the rx pin is asynchronous to clk_i.
`timescale 1ns/1ps
module lblm_link
  import lblm_pkg::*;
#(
  parameter logic [CNT_W-1:0] HALF_CYC = CNT_W'(HALF_BIT_CYC),
  parameter logic [CNT_W-1:0] WAIT_CYC = CNT_W'(ANSWER_WAIT_CYC)
) (
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  wire logic                ce_i,
  input  wire logic                send_i,
  input  wire logic [FWD_BITS-1:0] frame_i,
  input  wire logic                expect_i,
  input  wire logic                rx_i,
  output logic                     tx_o,
  output logic                     busy_o,
  output logic                     ans_valid_o,
  output logic                     ans_none_o,
  output logic [7:0]               ans_data_o
);
  typedef enum logic [1:0] {L_IDLE, L_TX, L_WAIT, L_RX} lblm_link_state_type;
  lblm_link_state_type state_reg;
  logic [CNT_W-1:0]      cnt_reg;
  logic [5:0]            idx_reg;
  logic [HALF_TOTAL-1:0] sh_reg;
  logic [HALF_TOTAL-1:0] halves;
  logic                  expect_reg;
  logic                  sync1_reg;
  logic                  sync2_reg;
  logic                  prev_reg;
  logic                  tx_reg;
  logic                  valid_reg;
  logic                  none_reg;
  logic [7:0]            data_reg;
  wire                   fall = prev_reg & ~sync2_reg;
  wire                   tick = (cnt_reg == '0);

  // Each bit is a low half then a high half for a one; start bit is a one.
  for (genvar i = 0; i <= FWD_BITS; i++) begin : g_half
    wire b = (i == 0) ? 1'b1 : frame_i[FWD_BITS - i];
    assign halves[HALF_TOTAL-1-2*i] = ~b;
    assign halves[HALF_TOTAL-2-2*i] = b;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else if (ce_i) begin
      sync1_reg <= rx_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg  <= L_IDLE;
      cnt_reg    <= '0;
      idx_reg    <= '0;
      sh_reg     <= '1;
      expect_reg <= 1'b0;
      tx_reg     <= 1'b1;
      valid_reg  <= 1'b0;
      none_reg   <= 1'b0;
      data_reg   <= '0;
    end else if (ce_i) begin
      valid_reg <= 1'b0;
      none_reg  <= 1'b0;
      case (state_reg)
        L_IDLE: begin
          tx_reg <= 1'b1;
          if (send_i) begin
            sh_reg     <= halves;
            expect_reg <= expect_i;
            idx_reg    <= '0;
            cnt_reg    <= '0;
            state_reg  <= L_TX;
          end
        end
        L_TX: begin
          if (tick) begin
            if (idx_reg == 6'(HALF_TOTAL)) begin
              tx_reg    <= 1'b1;
              cnt_reg   <= WAIT_CYC;
              state_reg <= expect_reg ? L_WAIT : L_IDLE;
            end else begin
              tx_reg  <= sh_reg[HALF_TOTAL-1];
              sh_reg  <= {sh_reg[HALF_TOTAL-2:0], 1'b1};
              idx_reg <= idx_reg + 6'h01;
              cnt_reg <= HALF_CYC - CNT_W'(1);
            end
          end else begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end
        L_WAIT: begin
          // First sample sits mid second half of the first data bit, where the
          // bit value shows; the fall and every sample share one sync delay.
          if (fall) begin
            cnt_reg   <= HALF_CYC + HALF_CYC + HALF_CYC + (HALF_CYC >> 1);
            idx_reg   <= '0;
            state_reg <= L_RX;
          end else if (tick) begin
            none_reg  <= 1'b1;
            state_reg <= L_IDLE;
          end else begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end
        L_RX: begin
          if (tick) begin
            data_reg <= {data_reg[6:0], sync2_reg};
            idx_reg  <= idx_reg + 6'h01;
            cnt_reg  <= HALF_CYC + HALF_CYC - CNT_W'(1);
            if (idx_reg == 6'(BACK_BITS - 1)) begin
              valid_reg <= 1'b1;
              state_reg <= L_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end
        end
        default: state_reg <= L_IDLE;
      endcase
    end
  end

  assign tx_o        = tx_reg;
  assign busy_o      = (state_reg != L_IDLE);
  assign ans_valid_o = valid_reg;
  assign ans_none_o  = none_reg;
  assign ans_data_o  = data_reg;
endmodule

// ==== lblm_manager.sv ====
// Lighting bus lamp manager: APB registers, trigger handling, command
// sequencing and read-back of level, status and fault bytes.
// Assumes one lamp bus port shared by all lines, chosen by line_sel_o.
// Functional notes
// - Commands go to the bus line chosen by the line-select field.
// - Address type 0 means single lamp, 1 means group address.
// - Maximum trigger commands lamp or group to maximum level.
// - Minimum trigger commands lamp or group to minimum level.
// - Off trigger switches the lamp or group off.
// - Brightness trigger sends the current brightness value.
// - Scene trigger transmits the current scene number.
// - Read trigger queries level, status, fault; single lamp only.
// - Level, status and fault outputs change only through a read.
// - Status bits 0..2: general alarm, lamp fault, lamp on.
// - Status bit 5 reset state, 6 unaddressed, 7 power cycle.
// - Fault bits 0..3: short, open, load down, load up.
// - Fault bits 4..7: overcurrent, thermal stop, overload, reference.
// - Alive clears on read trigger, sets when the lamp answers.
// - Transmit counter counts every message sent.
// - Receive counter counts every answer received.
// - Read-complete is 0 during a read, 1 afterwards.
// - With sync on, a missing answer forces the queried data output to zero.
`timescale 1ns/1ps
module lblm_manager
  import lblm_pkg::*;
#(
  parameter int               LINE_W   = 3,
  parameter int               CNT_OUT  = 16,
  parameter logic [CNT_W-1:0] HALF_CYC = CNT_W'(HALF_BIT_CYC),
  parameter logic [CNT_W-1:0] WAIT_CYC = CNT_W'(ANSWER_WAIT_CYC)
) (
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic               ce_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [7:0]         paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               bus_rx_i,
  output logic                    bus_tx_o,
  output logic      [LINE_W-1:0]  line_sel_o,
  output logic      [7:0]         light_level_out_o,
  output logic      [7:0]         status_o,
  output logic      [7:0]         fault_o,
  output logic                    alive_o,
  output logic                    read_done_o,
  output logic      [CNT_OUT-1:0] tx_count_o,
  output logic      [CNT_OUT-1:0] rx_count_o
);
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_HOLD} lblm_state_type;
  lblm_state_type     state_reg;
  logic [LINE_W-1:0]  line_reg;
  logic               type_reg;
  logic               sync_reg;
  logic [5:0]         addr_reg;
  logic [7:0]         bright_reg;
  logic [3:0]         scene_reg;
  logic [TRG_N-1:0]   trig_reg;
  logic [TRG_N-1:0]   pend_reg;
  logic [TRG_N-1:0]   pend_next;
  logic [TRG_N-1:0]   rise;
  logic [FWD_BITS-1:0] frame_reg;
  logic               expect_reg;
  logic               reading_reg;
  logic [1:0]         step_reg;
  logic [LINE_W-1:0]  sel_reg;
  logic [7:0]         level_reg;
  logic [7:0]         status_reg;
  logic [7:0]         fault_reg;
  logic               alive_reg;
  logic               done_reg;
  logic [CNT_OUT-1:0] txc_reg;
  logic [CNT_OUT-1:0] rxc_reg;
  logic [31:0]        rdata_reg;
  logic               link_busy;
  logic               ans_valid;
  logic               ans_none;
  logic [7:0]         ans_data;

  wire apb_setup = psel_i & ~penable_i;
  wire apb_acc   = psel_i & penable_i & ce_i;
  wire apb_wr    = apb_acc & pwrite_i;
  wire hit_cfg   = (paddr_i == OFS_CFG);
  wire hit_val   = (paddr_i == OFS_VALUE);
  wire hit_trig  = (paddr_i == OFS_TRIG);
  wire hit_any   = hit_cfg | hit_val | hit_trig | (paddr_i == OFS_RESULT)
                 | (paddr_i == OFS_COUNT) | (paddr_i == OFS_STATE);

  wire [31:0] rd_word =
      hit_cfg  ? {18'h0, addr_reg, 3'h0, sync_reg, type_reg, line_reg} :
      hit_val  ? {20'h0, scene_reg, bright_reg} :
      hit_trig ? {26'h0, trig_reg} :
      (paddr_i == OFS_RESULT) ? {8'h0, fault_reg, status_reg, level_reg} :
      (paddr_i == OFS_COUNT)  ? {rxc_reg, txc_reg} :
      (paddr_i == OFS_STATE)  ? {18'h0, pend_reg, 5'h0, reading_reg, done_reg, alive_reg} :
      32'h0;

  // Trigger levels are written by software; only their rising edges count.
  // edge detection
  lblm_edge #(.W(TRG_N)) u_edge (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .ce_i    (ce_i),
    .level_i (trig_reg),
    .rise_o  (rise)
  );

  // Lowest set pending bit wins; new edges are never lost to a clear.
  wire [TRG_N-1:0] pick     = pend_reg & (~pend_reg + 6'h01);
  wire             in_idle  = (state_reg == S_IDLE);
  wire             go_query = in_idle & reading_reg;
  wire             go_read  = in_idle & ~reading_reg & pick[TRG_READ];
  wire             go_cmd   = in_idle & ~reading_reg & (pend_reg != '0) & ~pick[TRG_READ];
  wire             finished = (state_reg == S_HOLD) & ~link_busy;
  wire             answered = finished & ans_valid;
  wire             missing  = finished & ~ans_valid;
  wire [TRG_N-1:0] clr      = (go_read | go_cmd) ? pick : '0;
  wire [TRG_N-1:0] accept   = type_reg ? (rise & ~(6'h01 << TRG_READ)) : rise;

  assign pend_next = (pend_reg & ~clr) | accept;

  wire direct   = pick[TRG_DIM];
  wire [7:0] addr_byte = type_reg ? {GROUP_PREFIX, addr_reg[3:0], ~direct}
                                  : {1'b0, addr_reg, ~direct};
  wire [7:0] cmd_byte =
      pick[TRG_MAX]   ? CMD_MAX :
      pick[TRG_MIN]   ? CMD_MIN :
      pick[TRG_DIM]   ? bright_reg :
      pick[TRG_SCENE] ? (CMD_SCENE | {4'h0, scene_reg}) :
      CMD_OFF;
  wire [7:0] query_byte = (step_reg == STEP_LEVEL)  ? CMD_Q_LEVEL :
                          (step_reg == STEP_STATUS) ? CMD_Q_STATUS : CMD_Q_FAULT;
  wire [7:0] qaddr_byte = {1'b0, addr_reg, 1'b1};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_reg   <= '0;
      type_reg   <= 1'b0;
      sync_reg   <= 1'b0;
      addr_reg   <= '0;
      bright_reg <= '0;
      scene_reg  <= '0;
      trig_reg   <= '0;
      rdata_reg  <= '0;
    end else if (ce_i) begin
      if (apb_setup) begin
        rdata_reg <= rd_word;
      end
      if (apb_wr & hit_cfg) begin
        line_reg <= pwdata_i[CFG_LINE_LSB +: LINE_W];
        type_reg <= pwdata_i[CFG_TYPE_BIT];
        sync_reg <= pwdata_i[CFG_SYNC_BIT];
        addr_reg <= pwdata_i[CFG_ADDR_LSB +: 6];
      end
      if (apb_wr & hit_val) begin
        bright_reg <= pwdata_i[VAL_BRT_LSB +: 8];
        scene_reg  <= pwdata_i[VAL_SCN_LSB +: 4];
      end
      if (apb_wr & hit_trig) begin
        trig_reg <= pwdata_i[TRG_N-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg   <= S_IDLE;
      pend_reg    <= '0;
      frame_reg   <= '0;
      expect_reg  <= 1'b0;
      reading_reg <= 1'b0;
      step_reg    <= STEP_LEVEL;
      sel_reg     <= '0;
      txc_reg     <= '0;
    end else if (ce_i) begin
      pend_reg <= pend_next;
      case (state_reg)
        S_IDLE: begin
          if (go_read) begin
            reading_reg <= 1'b1;
            step_reg    <= STEP_LEVEL;
          end else if (go_query | go_cmd) begin
            frame_reg  <= go_query ? {qaddr_byte, query_byte} : {addr_byte, cmd_byte};
            expect_reg <= go_query;
            state_reg  <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          sel_reg <= line_reg;
          txc_reg   <= txc_reg + CNT_OUT'(1);
          state_reg <= S_HOLD;
        end
        S_HOLD: begin
          if (finished) begin
            state_reg <= S_IDLE;
            if (reading_reg) begin
              step_reg <= step_reg + 2'h1;
              if (step_reg == STEP_FAULT) begin
                reading_reg <= 1'b0;
              end
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Status and fault bytes are passed through bit for bit from the lamp.
  // read-back capture
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_reg  <= '0;
      status_reg <= '0;
      fault_reg  <= '0;
    end else if (ce_i & reading_reg & (answered | (missing & sync_reg))) begin
      case (step_reg)
        STEP_LEVEL:  level_reg  <= answered ? ans_data : 8'h00;
        STEP_STATUS: status_reg <= answered ? ans_data : 8'h00;
        default:     fault_reg  <= answered ? ans_data : 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alive_reg <= 1'b0;
      done_reg  <= 1'b1;
      rxc_reg   <= '0;
    end else if (ce_i) begin
      if (go_read) begin
        alive_reg <= 1'b0;
      end else if (answered) begin
        alive_reg <= 1'b1;
      end
      if (go_read) begin
        done_reg <= 1'b0;
      end else if (finished & reading_reg & (step_reg == STEP_FAULT)) begin
        done_reg <= 1'b1;
      end
      if (answered) begin
        rxc_reg <= rxc_reg + CNT_OUT'(1);
      end
    end
  end

  lblm_link #(.HALF_CYC(HALF_CYC), .WAIT_CYC(WAIT_CYC)) u_link (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .send_i      (state_reg == S_ISSUE),
    .frame_i     (frame_reg),
    .expect_i    (expect_reg),
    .rx_i        (bus_rx_i),
    .tx_o        (bus_tx_o),
    .busy_o      (link_busy),
    .ans_valid_o (ans_valid),
    .ans_none_o  (ans_none),
    .ans_data_o  (ans_data)
  );

  // No wait states while ce_i is high; a frozen clock enable holds pready_o low and stalls the bus.
  assign pready_o          = ce_i;
  assign pslverr_o         = psel_i & penable_i & ~hit_any;
  assign prdata_o          = rdata_reg;
  assign line_sel_o        = sel_reg;
  assign light_level_out_o = level_reg;
  assign status_o          = status_reg;
  assign fault_o           = fault_reg;
  assign alive_o           = alive_reg;
  assign read_done_o       = done_reg;
  assign tx_count_o        = txc_reg;
  assign rx_count_o        = rxc_reg;

  sequence s_issue;
    ce_i && (state_reg == S_ISSUE);
  endsequence
  sequence s_held;
    state_reg == S_HOLD;
  endsequence

  property p_tx_count;
    @(posedge clk_i) disable iff (!nrst_i)
      s_issue |=> s_held ##0 (txc_reg == $past(txc_reg) + CNT_OUT'(1));
  endproperty
  a_tx_count: assert property (p_tx_count) else $error("tx count not stepped");

  property p_rx_count;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && answered) |=> (rxc_reg == $past(rxc_reg) + CNT_OUT'(1));
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("rx count not stepped");

  property p_alive_clear;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && go_read) |=> !alive_o && !read_done_o;
  endproperty
  a_alive_clear: assert property (p_alive_clear) else $error("read start flags wrong");

  property p_alive_set;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && answered && reading_reg) |=> alive_o;
  endproperty
  a_alive_set: assert property (p_alive_set) else $error("alive not set on answer");

  property p_busy_read;
    @(posedge clk_i) disable iff (!nrst_i)
      reading_reg |-> !read_done_o;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("read complete during read");

  property p_hold_outputs;
    @(posedge clk_i) disable iff (!nrst_i)
      !reading_reg |=> $stable(light_level_out_o) && $stable(status_o) && $stable(fault_o);
  endproperty
  a_hold_outputs: assert property (p_hold_outputs) else $error("data changed without read");

  property p_group_frame;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && go_cmd && type_reg) |=> (frame_reg[15:13] == GROUP_PREFIX);
  endproperty
  a_group_frame: assert property (p_group_frame) else $error("group address missing");

  property p_max_frame;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && go_cmd && pick[TRG_MAX]) |=> (frame_reg[7:0] == CMD_MAX) && frame_reg[8];
  endproperty
  a_max_frame: assert property (p_max_frame) else $error("max command wrong");

  property p_line_sel;
    @(posedge clk_i) disable iff (!nrst_i)
      s_issue |=> (line_sel_o == $past(line_reg));
  endproperty
  a_line_sel: assert property (p_line_sel) else $error("line select not applied");

  property p_no_group_read;
    @(posedge clk_i) disable iff (!nrst_i)
      (ce_i && type_reg) |=> !$rose(pend_reg[TRG_READ]);
  endproperty
  a_no_group_read: assert property (p_no_group_read) else $error("group read accepted");
endmodule

// ==== lblm_lamp.sv ====
// Behavioural lamp on the lamp bus: decodes forward frames, answers queries.
// Assumes tx idles high, a half-bit of H clock cycles and a pulled-up rx line.
`timescale 1ns/1ps
module lblm_lamp #(
  parameter int H = 4
) (
  input  wire logic        clk_i,
  input  wire logic        tx_i,
  input  wire logic        ans_en_i,
  input  wire logic [7:0]  lvl_i,
  input  wire logic [7:0]  sts_i,
  input  wire logic [7:0]  flt_i,
  output logic             rx_o,
  output int               n_frm_o,
  output logic      [15:0] frm_o
);
  logic [8:0] s;
  logic       is_query;
  initial begin
    rx_o <= 1'b1;
    n_frm_o = 0;
    frm_o = '0;
    forever begin
      @(negedge tx_i);
      // Sample mid second half of each bit, where no transition can fall.
      repeat (3 * H + H / 2) @(posedge clk_i);
      for (int i = 15; i >= 0; i--) begin
        frm_o[i] = tx_i;
        if (i > 0) repeat (2 * H) @(posedge clk_i);
      end
      n_frm_o++;
      // Only the three queries get an answer; commands leave the line idle.
      is_query = (frm_o[7:0] == 8'ha0) || (frm_o[7:0] == 8'h90) || (frm_o[7:0] == 8'hf1);
      if (frm_o[8] && ans_en_i && is_query) begin
        s = {1'b1, frm_o[7:0] == 8'ha0 ? lvl_i : frm_o[7:0] == 8'h90 ? sts_i : flt_i};
        repeat (8 * H) @(posedge clk_i);
        for (int i = 8; i >= 0; i--) begin
          rx_o <= ~s[i];
          repeat (H) @(posedge clk_i);
          rx_o <= s[i];
          repeat (H) @(posedge clk_i);
        end
        rx_o <= 1'b1;
      end
    end
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the lamp manager: APB master and a lamp model.
// Assumes short bus timing: half-bit of 4 cycles, answer wait of 200.
`timescale 1ns/1ps
module tb;
  import lblm_pkg::*;
  logic        clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, ans = 1;
  logic        rx, tx, prdy, perr, err, alive, rdone;
  logic [7:0]  paddr = '0, lvl, sts, flt;
  logic [31:0] pwdata = '0, prdata, q;
  logic [2:0]  line;
  logic [15:0] txc, rxc, frm;
  int          n_fail = 0, n_tests = 0, n_frm, cyc = 0;
  lblm_manager #(.HALF_CYC(CNT_W'(4)), .WAIT_CYC(CNT_W'(200))) i_dut (
    .clk_i(clk), .nrst_i(nrst), .ce_i(1'b1), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(prdy), .pslverr_o(perr), .bus_rx_i(rx), .bus_tx_o(tx),
    .line_sel_o(line), .light_level_out_o(lvl), .status_o(sts), .fault_o(flt),
    .alive_o(alive), .read_done_o(rdone), .tx_count_o(txc), .rx_count_o(rxc));
  lblm_lamp #(.H(4)) i_lamp (.clk_i(clk), .tx_i(tx), .ans_en_i(ans),
    .lvl_i(8'h5a), .sts_i(8'ha5), .flt_i(8'h3c), .rx_o(rx), .n_frm_o(n_frm),
    .frm_o(frm));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    q = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic trig(int b);
    apb(1, OFS_TRIG, 32'(1) << b);
    apb(1, OFS_TRIG, 0);
  endtask
  task automatic wfrm(int n);
    repeat (3000) if (n_frm < n) @(posedge clk);
    chk("frames", n, n_frm);
  endtask
  task automatic rd();
    trig(TRG_READ);
    chk("busy read done", 0, rdone);
    chk("alive cleared", 0, alive);
    repeat (3000) if (rdone !== 1'b1) @(posedge clk);
    chk("read finished", 1, rdone);
  endtask
  task automatic t_rst();
    chk("read done", 1, rdone);
    chk("tx idle", 1, tx);
    apb(1, OFS_RESULT, 32'hffffffff);
    apb(0, OFS_RESULT, 0);
    chk("ro result", 0, q);
    apb(0, 8'h18, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, q);
    $display("done reset");
  endtask
  task automatic t_cmds();
    logic [7:0] d [5] = '{CMD_MAX, CMD_MIN, CMD_OFF, 8'd85, CMD_SCENE | 8'h0f};
    apb(1, OFS_CFG, 32'h00002a05);
    apb(1, OFS_VALUE, 32'h00000f55);
    for (int i = 0; i < 5; i++) begin
      trig(i);
      wfrm(i + 1);
      chk("frame", {7'h2a, i != TRG_DIM, d[i]}, frm);
      chk("line", 5, line);
    end
    apb(1, OFS_TRIG, 32'h1);
    apb(1, OFS_TRIG, 32'h1);
    apb(1, OFS_TRIG, 32'h0);
    wfrm(6);
    repeat (300) @(posedge clk);
    chk("held trigger", 6, n_frm);
    chk("tx count", 6, txc);
    chk("rx count", 0, rxc);
    chk("level", 0, lvl);
    apb(1, OFS_CFG, 32'h00000b08);
    trig(TRG_MAX);
    wfrm(7);
    chk("group frame", 16'h9705, frm);
    chk("line", 0, line);
    trig(TRG_READ);
    repeat (300) @(posedge clk);
    chk("group read", 7, n_frm);
    chk("read done", 1, rdone);
    $display("done commands");
  endtask
  task automatic t_read();
    apb(1, OFS_CFG, 32'h00002a02);
    rd();
    chk("level", 8'h5a, lvl);
    chk("status", 8'ha5, sts);
    chk("fault", 8'h3c, flt);
    chk("alive", 1, alive);
    chk("rx count", 3, rxc);
    chk("tx count", 10, txc);
    chk("last query", 16'h55f1, frm);
    apb(0, OFS_RESULT, 0);
    chk("result reg", 32'h003ca55a, q);
    $display("done read");
  endtask
  task automatic t_noans();
    ans <= 1'b0;
    rd();
    chk("held level", 8'h5a, lvl);
    chk("alive", 0, alive);
    chk("rx count", 3, rxc);
    apb(1, OFS_CFG, 32'h00002a12);
    rd();
    chk("sync zero", 0, {lvl, sts, flt});
    $display("done no answer");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_rst();
    t_cmds();
    t_read();
    t_noans();
    wrap_up();
  end
endmodule
